// ==== hw/part_timer.v ====
/*
 * part_timer.v: 8-bit auto-reload pwm timer with 7-bit prescaler, four
 * double-buffered pwm channels, overflow time base and two input captures,
 * reached by software over an AXI4-Lite slave.
 * assumes: one clock mclk_in; pins are synchronous to it; halt_in is a level
 * from the power manager; the external clock pin is sampled and its rising
 * edge is used as an event.
 */
`timescale 1ns/1ps
`include "part_map.vh"

module part_timer
#(
	parameter NCH = 4,   // pwm channels
	parameter NCAP = 2   // capture channels
)
(
	input  wire            mclk_in,        // 125 MHz clock
	input  wire            rst_in,         // async reset, high
	input  wire [7:0]      s_axi_awaddr,   // write address
	input  wire            s_axi_awvalid,  // write address valid
	output wire            s_axi_awready,  // write address ready
	input  wire [31:0]     s_axi_wdata,    // write data
	input  wire [3:0]      s_axi_wstrb,    // write strobes
	input  wire            s_axi_wvalid,   // write data valid
	output wire            s_axi_wready,   // write data ready
	output reg  [1:0]      s_axi_bresp,    // write response
	output reg             s_axi_bvalid,   // write response valid
	input  wire            s_axi_bready,   // write response ready
	input  wire [7:0]      s_axi_araddr,   // read address
	input  wire            s_axi_arvalid,  // read address valid
	output wire            s_axi_arready,  // read address ready
	output reg  [31:0]     s_axi_rdata,    // read data
	output reg  [1:0]      s_axi_rresp,    // read response
	output reg             s_axi_rvalid,   // read data valid
	input  wire            s_axi_rready,   // read data ready
	input  wire            halt_in,        // device in halt mode
	input  wire            ext_clock_in,   // external clock pin
	input  wire [NCAP-1:0] capture_input_pin_in, // capture pins
	output reg  [NCH-1:0]  pulse_output_pin_out, // pwm pin levels
	output reg  [NCH-1:0]  pulse_oe_n_out, // pin drive enable, low=drive
	output wire            overflow_irq_out,     // overflow request
	output wire [NCAP-1:0] capture_irq_out,      // capture requests
	output wire            wake_out        // wake from halt
);

	// software registers
	reg  [7:0]      timer_control_status; // flag bit kept in overflow_flag
	reg  [7:0]      counter_access;
	reg  [7:0]      auto_reload_value;
	reg  [7:0]      pwm_output_control;
	reg  [7:0]      duty_cycle_value [0:NCH-1];
	reg  [7:0]      hidden_compare_value [0:NCH-1];
	reg  [NCAP-1:0] capture_edge_select;
	reg  [NCAP-1:0] capture_irq_enable;
	reg  [NCAP-1:0] capture_flag;
	reg  [7:0]      capture_value [0:NCAP-1];
	reg             overflow_flag;
	reg  [6:0]      prescaler;
	reg  [NCH-1:0]  pwm_raw;      // level before polarity
	reg             ext_prev;
	reg  [NCAP-1:0] cap_prev;

	// bus side state
	reg             aw_held;
	reg             w_held;
	reg  [7:0]      aw_addr;
	reg  [31:0]     w_data;
	reg  [3:0]      w_strb;

	integer i;

	wire       ext_sel = timer_control_status[`PART_CS_EXTERNAL_CLOCK_SELECT];
	wire [2:0] psc_sel =
		timer_control_status[`PART_CS_PSC_HI:`PART_CS_PSC_LO];
	wire       cnt_en = timer_control_status[`PART_CS_TCE];
	wire [NCH-1:0] oe = pwm_output_control[`PART_PC_OE +: NCH];
	wire [NCH-1:0] pol = pwm_output_control[`PART_PC_POL +: NCH];

	// true when a stored byte lane 0 write hits the given address
	function wr_hit;
		input [7:0] a;
		input [7:0] target;
		input [3:0] strb;
		begin
			wr_hit = (a == target) && strb[0];
		end
	endfunction

	// tick of the 2^n prescaler tap: all lower bits set
	function tap_tick;
		input [6:0] p;
		input [2:0] n;
		reg   [6:0] m;
		begin
			m = (7'h01 << n) - 7'h01;
			tap_tick = ((p & m) == m);
		end
	endfunction

	// write channel: take address and data in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	wire wr_go = aw_held && w_held && !s_axi_bvalid;
	wire [7:0] wa = aw_addr;
	wire [7:0] wd = w_data[7:0];

	// read channel: one read outstanding, answered next cycle
	assign s_axi_arready = !s_axi_rvalid;
	wire rd_go = s_axi_arvalid && s_axi_arready;

	// register file writes from software
	wire wr_csr = wr_go && wr_hit(wa, `PART_ADDR_CTLSTAT, w_strb);
	wire wr_cnt = wr_go && wr_hit(wa, `PART_ADDR_CNT, w_strb);
	wire force_rl = wr_csr && wd[`PART_CS_FORCE_RELOAD];

	// side effects of reads
	wire rd_csr = rd_go && (s_axi_araddr == `PART_ADDR_CTLSTAT);
	wire [NCAP-1:0] rd_cap;
	assign rd_cap[0] = rd_go && (s_axi_araddr == `PART_ADDR_CAP1);
	assign rd_cap[1] = rd_go && (s_axi_araddr == `PART_ADDR_CAP2);

	// clock source: cpu clock every cycle or a sampled external rising edge
	wire ext_edge = ext_clock_in && !ext_prev;
	wire src_tick = ext_sel ? ext_edge : 1'b1;
	// halt stops the whole counting chain, so pwm freezes too
	wire run = cnt_en && !halt_in && src_tick;
	wire cnt_tick = run && tap_tick(prescaler, psc_sel);
	wire ovf = cnt_tick && (counter_access == `PART_CNT_MAX);

	// capture edges per channel
	wire [NCAP-1:0] cap_edge =
		(capture_input_pin_in & ~cap_prev & capture_edge_select) |
		(~capture_input_pin_in & cap_prev & ~capture_edge_select);

	// bus handshake state
	always @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PART_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// unmapped or read-only words answer slave error
				s_axi_bresp <= (wa > `PART_ADDR_CAPCTL || wa[1:0] != 2'b00) ?
					`PART_RESP_SLVERR : `PART_RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read data path, registered
	always @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PART_RESP_OKAY;
		end
		else if (rd_go)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `PART_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			case (s_axi_araddr)
			`PART_ADDR_DUTY0:  s_axi_rdata[7:0] <= duty_cycle_value[0];
			`PART_ADDR_DUTY1:  s_axi_rdata[7:0] <= duty_cycle_value[1];
			`PART_ADDR_DUTY2:  s_axi_rdata[7:0] <= duty_cycle_value[2];
			`PART_ADDR_DUTY3:  s_axi_rdata[7:0] <= duty_cycle_value[3];
			`PART_ADDR_PWMCTL: s_axi_rdata[7:0] <= pwm_output_control;
			// force reload reads as zero, flag shows live
			`PART_ADDR_CTLSTAT: s_axi_rdata[7:0] <=
				{timer_control_status[`PART_CS_EXTERNAL_CLOCK_SELECT:`PART_CS_TCE],
				 1'b0,
				 timer_control_status[`PART_CS_OIE], overflow_flag};
			`PART_ADDR_CNT:    s_axi_rdata[7:0] <= counter_access;
			`PART_ADDR_RELOAD: s_axi_rdata[7:0] <= auto_reload_value;
			`PART_ADDR_CAPCTL: s_axi_rdata[7:0] <=
				{2'b00, capture_edge_select, capture_irq_enable, capture_flag};
			`PART_ADDR_CAP1:   s_axi_rdata[7:0] <= capture_value[0];
			`PART_ADDR_CAP2:   s_axi_rdata[7:0] <= capture_value[1];
			`PART_ADDR_HALT:   s_axi_rdata[0] <= halt_in;
			default:           s_axi_rresp <= `PART_RESP_SLVERR;
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// control registers written by software
	always @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			timer_control_status <= `PART_BYTE_ZERO;
			auto_reload_value <= `PART_BYTE_ZERO;
			pwm_output_control <= `PART_BYTE_ZERO;
			capture_edge_select <= {NCAP{1'b0}};
			capture_irq_enable <= {NCAP{1'b0}};
			for (i = 0; i < NCH; i = i + 1)
				duty_cycle_value[i] <= `PART_BYTE_ZERO;
		end
		else if (wr_go && w_strb[0])
		begin
			case (wa)
			`PART_ADDR_DUTY0:  duty_cycle_value[0] <= wd;
			`PART_ADDR_DUTY1:  duty_cycle_value[1] <= wd;
			`PART_ADDR_DUTY2:  duty_cycle_value[2] <= wd;
			`PART_ADDR_DUTY3:  duty_cycle_value[3] <= wd;
			`PART_ADDR_PWMCTL: pwm_output_control <= wd;
			// flag and force reload bits are not stored
			`PART_ADDR_CTLSTAT: timer_control_status <=
				{wd[`PART_CS_EXTERNAL_CLOCK_SELECT:`PART_CS_TCE], 1'b0,
				 wd[`PART_CS_OIE], 1'b0};
			`PART_ADDR_RELOAD: auto_reload_value <= wd;
			`PART_ADDR_CAPCTL:
			begin
				capture_edge_select <= wd[`PART_CC_EDGE +: NCAP];
				capture_irq_enable <= wd[`PART_CC_IE +: NCAP];
			end
			default: ;
			endcase
		end
	end

	// prescaler and counter
	always @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			prescaler <= `PART_PSC_ZERO;
			counter_access <= `PART_BYTE_ZERO;
			ext_prev <= 1'b0;
		end
		else
		begin
			ext_prev <= ext_clock_in;
			if (wr_cnt)
			begin
				// software load wins over counting in the same cycle
				counter_access <= wd;
				prescaler <= `PART_PSC_ZERO;
			end
			else if (force_rl)
			begin
				counter_access <= auto_reload_value;
				prescaler <= `PART_PSC_ZERO;
			end
			else if (run)
			begin
				prescaler <= prescaler + 7'h01;
				if (ovf)
					counter_access <= auto_reload_value;
				else if (cnt_tick)
					counter_access <= counter_access + 8'h01;
			end
		end
	end

	// overflow flag: a new overflow wins over the clearing read
	always @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			overflow_flag <= 1'b0;
		else if (ovf)
			overflow_flag <= 1'b1;
		else if (rd_csr)
			overflow_flag <= 1'b0;
	end

	// double buffered compare and raw pwm level
	always @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pwm_raw <= {NCH{1'b0}};
			for (i = 0; i < NCH; i = i + 1)
				hidden_compare_value[i] <= `PART_BYTE_ZERO;
		end
		else
		begin
			for (i = 0; i < NCH; i = i + 1)
			begin
				if (ovf)
				begin
					// copy only here so a change never glitches mid period
					hidden_compare_value[i] <= duty_cycle_value[i];
					pwm_raw[i] <= 1'b1;
				end
				else if (cnt_tick &&
					counter_access == hidden_compare_value[i])
					pwm_raw[i] <= 1'b0;
			end
		end
	end

	// polarity applied combinationally so a change acts at once; the pin
	// itself is registered, so it shows one clock after the register write
	wire [NCH-1:0] next_pwm_level = pwm_raw ^ pol;

	// pin levels and drive enables
	always @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pulse_output_pin_out <= {NCH{1'b0}};
			pulse_oe_n_out <= {NCH{1'b1}};
		end
		else
		begin
			pulse_output_pin_out <= oe & (next_pwm_level);
			pulse_oe_n_out <= ~oe;
		end
	end

	// capture channels: a new edge is ignored while the flag stands
	always @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cap_prev <= {NCAP{1'b0}};
			capture_flag <= {NCAP{1'b0}};
			for (i = 0; i < NCAP; i = i + 1)
				capture_value[i] <= `PART_BYTE_ZERO;
		end
		else
		begin
			cap_prev <= capture_input_pin_in;
			for (i = 0; i < NCAP; i = i + 1)
			begin
				if (cap_edge[i] && !capture_flag[i])
				begin
					capture_value[i] <= counter_access;
					capture_flag[i] <= 1'b1;
				end
				else if (rd_cap[i])
					capture_flag[i] <= 1'b0;
			end
		end
	end

	// interrupt requests and halt wake
	assign overflow_irq_out = overflow_flag &
		timer_control_status[`PART_CS_OIE];
	assign capture_irq_out = capture_flag & capture_irq_enable;
	assign wake_out = halt_in && (|capture_irq_out);

endmodule

// ==== hw/part_map.vh ====
/*
 * part_map.vh: register map, field positions, reset values, counter top and
 * bus response codes of the pwm auto-reload timer.
 * assumes: included by the timer core; byte registers sit in the low bits
 * of aligned 32-bit AXI4-Lite words, upper bits read as zero.
 */
`ifndef PART_MAP_VH
`define PART_MAP_VH

// byte addresses of the register words
`define PART_ADDR_DUTY0     8'h00
`define PART_ADDR_DUTY1     8'h04
`define PART_ADDR_DUTY2     8'h08
`define PART_ADDR_DUTY3     8'h0c
`define PART_ADDR_PWMCTL    8'h10
`define PART_ADDR_CTLSTAT   8'h14
`define PART_ADDR_CNT       8'h18
`define PART_ADDR_RELOAD    8'h1c
`define PART_ADDR_CAPCTL    8'h20
`define PART_ADDR_CAP1      8'h24
`define PART_ADDR_CAP2      8'h28
`define PART_ADDR_HALT      8'h2c

// timer_control_status fields
`define PART_CS_EXTERNAL_CLOCK_SELECT        7
`define PART_CS_PSC_HI      6
`define PART_CS_PSC_LO      4
`define PART_CS_TCE         3
`define PART_CS_FORCE_RELOAD        2
`define PART_CS_OIE         1
`define PART_CS_OVF         0

// capture_control_status fields
`define PART_CC_EDGE        4
`define PART_CC_IE          2
`define PART_CC_FLAG        0

// pwm_output_control fields
`define PART_PC_OE          4
`define PART_PC_POL         0

`define PART_BYTE_ZERO      8'h00
`define PART_CNT_MAX        8'hff
`define PART_PSC_ZERO       7'h00
`define PART_RESP_OKAY      2'b00
`define PART_RESP_SLVERR    2'b10

`endif

// ==== test/part_timer_properties.sv ====
/*
 * part_timer_properties.sv: port-level checks of the pwm timer.
 * assumes: bound to part_timer; one clock, async active-high reset.
 */
`timescale 1ns/1ps
`include "part_map.vh"
module part_props
#(
	parameter NCH = 4,   // pwm channels
	parameter NCAP = 2   // capture channels
)
(
	input wire            mclk_in,              // clock
	input wire            rst_in,               // reset
	input wire [7:0]      s_axi_araddr,         // read address
	input wire            s_axi_arvalid,        // read address valid
	input wire            s_axi_arready,        // read address ready
	input wire [31:0]     s_axi_rdata,          // read data
	input wire            s_axi_rvalid,         // read valid
	input wire            s_axi_wvalid,         // write data valid
	input wire            s_axi_bvalid,         // write response valid
	input wire            halt_in,              // halt level
	input wire [NCH-1:0]  pulse_output_pin_out, // pwm pins
	input wire [NCH-1:0]  pulse_oe_n_out,       // pin drive, low=drive
	input wire            overflow_irq_out,     // overflow request
	input wire [NCAP-1:0] capture_irq_out,      // capture requests
	input wire            wake_out              // wake request
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	// undriven channels must sit low
	property p_off_low;
		(pulse_oe_n_out & pulse_output_pin_out) == '0;
	endproperty
	a_off_low: assert property (p_off_low)
		else $error("disabled pin high");

	// writes excluded: polarity may legally flip the pin in halt
	property p_halt_hold;
		halt_in && $past(halt_in) && $past(halt_in, 2) &&
		!$past(s_axi_bvalid) |-> $stable(pulse_output_pin_out);
	endproperty
	a_halt_hold: assert property (p_halt_hold)
		else $error("pwm moved in halt");

	property p_wake;
		halt_in && capture_irq_out != '0 |-> wake_out;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake on capture request");

	// only a read of the capture word or a write may drop it
	property p_cap_hold;
		capture_irq_out[0] && !s_axi_wvalid && !$past(s_axi_wvalid) &&
		!(s_axi_arvalid && s_axi_arready &&
		  s_axi_araddr == `PART_ADDR_CAP1)
		|=> capture_irq_out[0];
	endproperty
	a_cap_hold: assert property (p_cap_hold)
		else $error("capture request dropped");

	property p_ovf_hold;
		overflow_irq_out && !s_axi_wvalid && !$past(s_axi_wvalid) &&
		!(s_axi_arvalid && s_axi_arready &&
		  s_axi_araddr == `PART_ADDR_CTLSTAT)
		|=> overflow_irq_out;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold)
		else $error("overflow request dropped");

	property p_force_reload_zero;
		$rose(s_axi_rvalid) && $past(s_axi_araddr) == `PART_ADDR_CTLSTAT
		|-> !s_axi_rdata[2];
	endproperty
	a_force_reload_zero: assert property (p_force_reload_zero)
		else $error("force reload read as one");

	property p_rd_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_rd_upper: assert property (p_rd_upper)
		else $error("upper read bits set");

	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered");
endmodule

bind part_timer part_props #(.NCH(NCH), .NCAP(NCAP)) chk_u
(
	.mclk_in, .rst_in, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_wvalid, .s_axi_bvalid, .halt_in,
	.pulse_output_pin_out, .pulse_oe_n_out, .overflow_irq_out,
	.capture_irq_out, .wake_out
);

// ==== test/pwm_auto_reload_timer_bench.sv ====
/*
 * pwm_auto_reload_timer_bench.sv: self-checking bench of the pwm timer.
 * assumes: part_timer and part_map.vh on the include path.
 */
`timescale 1ns/1ps
`include "part_map.vh"
module pwm_auto_reload_timer_bench;
	reg         mclk_in = 1'b0, rst_in = 1'b1, halt = 1'b0, ext_clk = 1'b0;
	reg  [7:0]  awaddr = 8'h00, araddr = 8'h00, k;
	reg  [31:0] wdata = 32'h0, rd_data;
	reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	reg         arvalid = 1'b0, rready = 1'b0;
	reg  [1:0]  cap_pin = 2'b10, resp;
	reg  [3:0]  held;
	wire        awready, wready, bvalid, arready, rvalid, ovf_irq, wake;
	wire [1:0]  bresp, rresp, cap_irq;
	wire [31:0] rdata;
	wire [3:0]  pin, oe_n;
	integer     miscompares = 0, check_count = 0, wait_n = 0;

	always #4 mclk_in = ~mclk_in;

	part_timer dut_u (.mclk_in(mclk_in), .rst_in(rst_in),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .halt_in(halt),
		.ext_clock_in(ext_clk), .capture_input_pin_in(cap_pin),
		.pulse_output_pin_out(pin), .pulse_oe_n_out(oe_n),
		.overflow_irq_out(ovf_irq), .capture_irq_out(cap_irq),
		.wake_out(wake));

	task close_out;
	begin
		$display("mismatches %0d of %0d checks", miscompares, check_count);
		if (miscompares == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	task chk(input [31:0] seen, input [31:0] exp);
	begin
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask

	// one cycle of a bounded wait; a hang ends the run
	task step;
	begin
		@(posedge mclk_in);
		wait_n = wait_n + 1;
		if (wait_n > 500)
		begin
			miscompares = miscompares + 1;
			$display("Error at %0t: wait ran out", $time);
			close_out;
		end
	end
	endtask

	// address and data offered together, each dropped once taken
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(posedge mclk_in);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		wait_n = 0;
		while (bvalid !== 1'b1)
		begin
			step;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		resp = bresp;
		bready <= 1'b0;
	end
	endtask

	task rd(input [7:0] a);
	begin
		@(posedge mclk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		wait_n = 0;
		while (rvalid !== 1'b1)
		begin
			step;
			if (arready)
				arvalid <= 1'b0;
		end
		rd_data = rdata;
		resp = rresp;
		rready <= 1'b0;
	end
	endtask

	// high then low length of one pwm period, in clocks
	task meas(input integer ch, input integer hi, input integer lo);
		integer h, l;
	begin
		wait_n = 0;
		h = 0;
		l = 0;
		while (pin[ch] !== 1'b0) step;
		while (pin[ch] !== 1'b1) step;
		while (pin[ch] === 1'b1)
		begin
			step;
			h = h + 1;
		end
		while (pin[ch] === 1'b0)
		begin
			step;
			l = l + 1;
		end
		chk(h, hi);
		chk(l, lo);
	end
	endtask

	task t_reset;
	begin
		chk(oe_n, 4'hf);
		for (k = 8'h00; k < 8'h30; k = k + 8'h04)
		begin
			rd(k);
			chk(rd_data, 32'h0);
		end
		rd(8'h30);
		chk(resp, `PART_RESP_SLVERR);
		wr(8'h34, 8'h01);
		chk(resp, `PART_RESP_SLVERR);
	end
	endtask

	// reload fc, compare fe: 3 ticks high, 1 low, scaled by prescaler
	task t_pwm;
	begin
		wr(`PART_ADDR_RELOAD, 8'hfc);
		for (k = 8'h00; k < 8'h04; k = k + 8'h01)
			wr(k << 2, 8'hfe); // compare above reload
		wr(`PART_ADDR_PWMCTL, 8'h50);
		repeat (2) @(posedge mclk_in);
		chk(oe_n, 4'ha);
		wr(`PART_ADDR_PWMCTL, 8'hf8);
		for (k = 8'h00; k < 8'h03; k = k + 8'h01)
		begin
			wr(`PART_ADDR_CTLSTAT, {1'b0, k[2:0], 4'hc});
			meas(k, 3 << k, 1 << k);
		end
		meas(3, 4, 12);
		wr(`PART_ADDR_DUTY0, 8'hfd);
		meas(0, 8, 8);
		halt <= 1'b1;
		repeat (3) @(posedge mclk_in);
		held = pin;
		repeat (40) @(posedge mclk_in);
		chk(pin, held);
		halt <= 1'b0;
		wr(`PART_ADDR_CTLSTAT, 8'h00);
	end
	endtask

	// reload 0, compare ff: full resolution, 100% then 0% by polarity
	task t_res;
		integer n;
	begin
		wr(`PART_ADDR_RELOAD, 8'h00);
		wr(`PART_ADDR_DUTY0, 8'hff);
		wr(`PART_ADDR_PWMCTL, 8'h10);
		wr(`PART_ADDR_CTLSTAT, 8'h0c);
		// one full period first, so the ff compare is in force
		repeat (300) @(posedge mclk_in);
		n = 0;
		repeat (300)
		begin
			@(posedge mclk_in);
			n = n + pin[0];
		end
		chk(n, 300);
		wr(`PART_ADDR_PWMCTL, 8'h11);
		repeat (2) @(posedge mclk_in);
		n = 0;
		repeat (300)
		begin
			@(posedge mclk_in);
			n = n + pin[0];
		end
		chk(n, 0);
		wr(`PART_ADDR_CTLSTAT, 8'h00);
	end
	endtask

	task pulse;
	begin
		repeat (3) @(posedge mclk_in);
		ext_clk <= 1'b1;
		repeat (3) @(posedge mclk_in);
		ext_clk <= 1'b0;
		repeat (3) @(posedge mclk_in);
	end
	endtask

	// external events, reload fd: flag after exactly three
	task t_ovf;
	begin
		rd(`PART_ADDR_CTLSTAT);
		wr(`PART_ADDR_RELOAD, 8'hfd);
		wr(`PART_ADDR_CTLSTAT, 8'h8e);
		pulse;
		pulse;
		rd(`PART_ADDR_CTLSTAT);
		chk(rd_data, 32'h8a);
		pulse;
		chk(ovf_irq, 1'b1);
		rd(`PART_ADDR_CTLSTAT);
		chk(rd_data, 32'h8b);
		@(posedge mclk_in);
		chk(ovf_irq, 1'b0);
		wr(`PART_ADDR_CTLSTAT, 8'h00);
		rd(`PART_ADDR_CNT);
		chk(rd_data, 32'hfd);
	end
	endtask

	// ch0 rising, ch1 falling, both with requests on
	task t_cap;
	begin
		wr(`PART_ADDR_CAPCTL, 8'h1c);
		wr(`PART_ADDR_CNT, 8'h37);
		repeat (10) @(posedge mclk_in);
		rd(`PART_ADDR_CNT);
		chk(rd_data, 32'h37);
		cap_pin[0] <= 1'b1;
		repeat (6) @(posedge mclk_in);
		chk(cap_irq, 2'b01);
		halt <= 1'b1; // counter already disabled before halt
		repeat (2) @(posedge mclk_in);
		chk(wake, 1'b1);
		halt <= 1'b0;
		wr(`PART_ADDR_CNT, 8'h55);
		cap_pin <= 2'b00;
		repeat (6) @(posedge mclk_in);
		cap_pin[0] <= 1'b1;
		repeat (6) @(posedge mclk_in);
		chk(cap_irq, 2'b11);
		rd(`PART_ADDR_CAP1);
		chk(rd_data, 32'h37);
		@(posedge mclk_in);
		chk(cap_irq, 2'b10);
		rd(`PART_ADDR_CAP2);
		chk(rd_data, 32'h55);
		rd(`PART_ADDR_CAPCTL);
		chk(rd_data, 32'h1c);
	end
	endtask

	// reset for 8 clocks, then the scenarios in turn
	initial
	begin
		repeat (8) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_reset;
		t_pwm;
		t_res;
		t_ovf;
		t_cap;
		close_out;
	end
endmodule
